/* rtl/swst_status.sv */
`timescale 1ns/10ps
module swst_status (
    input wire logic clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic restart,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic [3:0] switch_overload_evt,
    input wire logic [3:0] switch_open_load_evt,
    input wire logic [2:0] can_mode,
    input wire logic config_valid_bit,
    input wire logic config_error,
    input wire logic frame_valid,
    input wire logic frame_error,
    input wire logic bus_silence_exceeded,
    input wire logic wake_pattern_seen,
    input wire logic wake_frame_match,
    input wire logic ratio_strobe,
    input wire logic [11:0] clocks_per_bit_ratio,
    output logic system_fault_flag,
    output logic plain_can_wake_enable,
    output logic partial_wake_active_flag
);
    // ==========================================
    // State
    logic [3:0] overload_r, overload_nxt;
    logic [3:0] open_load_r, open_load_nxt;
    logic sync_r, sync_nxt;
    logic active_r, active_nxt;
    logic pattern_r, pattern_nxt;
    logic frame_r, frame_nxt;
    logic fault_r, fault_nxt;
    logic plain_wake_r, plain_wake_nxt;
    logic [5:0] tally_r, tally_nxt;
    logic [7:0] timing_high_r, timing_high_nxt;
    logic [3:0] timing_low_r, timing_low_nxt;
    logic [2:0] mode_prev_r;
    logic [2:0] mode_prev_nxt;
    swst_pkg::swst_ser_e ser_r, ser_nxt;
    logic sclk_prev_r, sclk_prev_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_in_r, shift_in_nxt;
    logic [7:0] shift_out_r, shift_out_nxt;
    logic sdo_r, sdo_nxt;
    logic sdo_oe_n_r, sdo_oe_n_nxt;

    logic [7:0] read_data;
    logic [7:0] quiet_view;
    logic [6:0] cmd_addr;
    logic cmd_done;
    logic mode_changed;
    logic overflow;

    // ==========================================
    // Read multiplexer; reserved bits are constant zero
    always_comb begin
        quiet_view = '0;
        quiet_view[swst_pkg::SYNC_BIT] = sync_r;
        quiet_view[swst_pkg::QUIET_BIT] = active_r & bus_silence_exceeded;
        quiet_view[swst_pkg::ACTIVE_BIT] = active_r;
        quiet_view[swst_pkg::PATTERN_BIT] = pattern_r;
        quiet_view[swst_pkg::FRAME_BIT] = frame_r;
        cmd_addr = {shift_in_r[5:0], spi_sdi};
        case (cmd_addr)
            swst_pkg::ADDR_SWITCH_OVERLOAD: read_data = {4'h0, overload_r};
            swst_pkg::ADDR_SWITCH_OPEN_LOAD: read_data = {4'h0, open_load_r};
            swst_pkg::ADDR_PARTIAL_WAKE: read_data = quiet_view;
            swst_pkg::ADDR_ERROR_TALLY: read_data = {2'h0, tally_r};
            swst_pkg::ADDR_TIMING_HIGH: read_data = timing_high_r;
            swst_pkg::ADDR_TIMING_LOW: read_data = {timing_low_r, 4'h0};
            default: read_data = 8'h00;
        endcase
    end

    // ==========================================
    // Next-state logic
    always_comb begin
        ser_nxt = ser_r;
        sclk_prev_nxt = spi_sclk;
        bit_cnt_nxt = bit_cnt_r;
        shift_in_nxt = shift_in_r;
        shift_out_nxt = shift_out_r;
        sdo_nxt = sdo_r;
        sdo_oe_n_nxt = sdo_oe_n_r;
        cmd_done = 1'b0;

        // Serial port: sample on rising clock, shift data out on falling clock
        // Limitation: sclk must be seen high and low for at least one clk edge each
        case (ser_r)
            swst_pkg::SER_IDLE: begin
                sdo_oe_n_nxt = 1'b1;
                if (!spi_csn) begin
                    ser_nxt = swst_pkg::SER_CMD;
                    bit_cnt_nxt = '0;
                    sdo_oe_n_nxt = 1'b0;
                    sdo_nxt = 1'b0;
                end
            end
            swst_pkg::SER_CMD: begin
                if (spi_sclk && !sclk_prev_r) begin
                    shift_in_nxt = {shift_in_r[6:0], spi_sdi};
                    bit_cnt_nxt = bit_cnt_r + 4'h1;
                    if (bit_cnt_r == swst_pkg::CMD_LAST_BIT) begin
                        cmd_done = 1'b1;
                        shift_out_nxt = read_data;
                        ser_nxt = swst_pkg::SER_DATA;
                    end
                end
            end
            swst_pkg::SER_DATA: begin
                if (!spi_sclk && sclk_prev_r) begin
                    sdo_nxt = shift_out_r[7];
                    shift_out_nxt = {shift_out_r[6:0], 1'b0};
                end
                if (spi_sclk && !sclk_prev_r && bit_cnt_r != swst_pkg::FRAME_LAST_BIT) begin
                    bit_cnt_nxt = bit_cnt_r + 4'h1;
                end
            end
            default: ser_nxt = swst_pkg::SER_IDLE;
        endcase
        // Raising csn aborts a frame in any state
        if (spi_csn) begin
            ser_nxt = swst_pkg::SER_IDLE;
            sdo_oe_n_nxt = 1'b1;
        end

        // ==========================================
        // Switch faults; set beats the read clear
        overload_nxt = overload_r;
        open_load_nxt = open_load_r;
        if (cmd_done && cmd_addr == swst_pkg::ADDR_SWITCH_OVERLOAD) begin
            overload_nxt = overload_r & ~read_data[3:0];
        end
        if (cmd_done && cmd_addr == swst_pkg::ADDR_SWITCH_OPEN_LOAD) begin
            open_load_nxt = open_load_r & ~read_data[3:0];
        end
        overload_nxt = overload_nxt | switch_overload_evt;
        open_load_nxt = open_load_nxt | switch_open_load_evt;

        // ==========================================
        // Partial wake control
        mode_prev_nxt = can_mode;
        mode_changed = (can_mode != mode_prev_r);
        sync_nxt = sync_r;
        active_nxt = active_r;
        pattern_nxt = pattern_r;
        frame_nxt = frame_r;
        fault_nxt = fault_r;
        plain_wake_nxt = plain_wake_r;
        tally_nxt = tally_r;

        if (mode_changed && can_mode != swst_pkg::MODE_NO_ACTIVATION) begin
            active_nxt = !fault_r && config_valid_bit && can_mode[swst_pkg::MODE_WAKE_BIT];
            if (active_nxt) begin
                plain_wake_nxt = 1'b0;
                pattern_nxt = 1'b0;
                frame_nxt = 1'b0;
            end
        end
        if (!can_mode[swst_pkg::MODE_WAKE_BIT]) begin
            active_nxt = 1'b0;
        end

        // Error wins over valid in one cycle; tally freezes at overflow
        if (active_r) begin
            if (frame_error && tally_r != swst_pkg::TALLY_OVERFLOW) begin
                tally_nxt = tally_r + 6'h01;
            end else if (frame_valid && tally_r != 6'h00) begin
                tally_nxt = tally_r - 6'h01;
            end
            if (frame_valid) begin
                sync_nxt = 1'b1;
            end
            if (wake_pattern_seen) begin
                pattern_nxt = 1'b1;
            end
            if (wake_frame_match) begin
                frame_nxt = 1'b1;
            end
        end

        overflow = (tally_nxt == swst_pkg::TALLY_OVERFLOW) && active_r;
        if (overflow) begin
            active_nxt = 1'b0;
            plain_wake_nxt = 1'b1;
        end
        // Fault only tracks while the wake mode bit is set
        if (can_mode[swst_pkg::MODE_WAKE_BIT] && (overflow || config_error)) begin
            fault_nxt = 1'b1;
        end
        if (!active_nxt) begin
            sync_nxt = 1'b0;
        end

        // ==========================================
        // Ratio snapshot; both halves load together except under restart, which holds only the high byte
        timing_high_nxt = timing_high_r;
        timing_low_nxt = timing_low_r;
        if (ratio_strobe) begin
            timing_high_nxt = clocks_per_bit_ratio[11:4];
            timing_low_nxt = clocks_per_bit_ratio[3:0];
        end

        // ==========================================
        // Restart keeps the switch faults, timing high byte, tally and sync flag; reserved bits have no storage to clear
        if (restart) begin
            overload_nxt = overload_r;
            open_load_nxt = open_load_r;
            timing_high_nxt = timing_high_r;
            tally_nxt = tally_r;
            sync_nxt = sync_r;
        end
        if (soft_reset) begin
            overload_nxt = '0;
            open_load_nxt = '0;
            sync_nxt = 1'b0;
            active_nxt = 1'b0;
            pattern_nxt = 1'b0;
            frame_nxt = 1'b0;
            fault_nxt = 1'b0;
            plain_wake_nxt = 1'b0;
            tally_nxt = '0;
            timing_high_nxt = swst_pkg::TIMING_HIGH_RESET;
            timing_low_nxt = swst_pkg::TIMING_LOW_RESET;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overload_r <= '0;
            open_load_r <= '0;
            sync_r <= 1'b0;
            active_r <= 1'b0;
            pattern_r <= 1'b0;
            frame_r <= 1'b0;
            fault_r <= 1'b0;
            plain_wake_r <= 1'b0;
            tally_r <= '0;
            timing_high_r <= swst_pkg::TIMING_HIGH_RESET;
            timing_low_r <= swst_pkg::TIMING_LOW_RESET;
            mode_prev_r <= '0;
            ser_r <= swst_pkg::SER_IDLE;
            sclk_prev_r <= 1'b0;
            bit_cnt_r <= '0;
            shift_in_r <= '0;
            shift_out_r <= '0;
            sdo_r <= 1'b0;
            sdo_oe_n_r <= 1'b1;
        end else begin
            overload_r <= overload_nxt;
            open_load_r <= open_load_nxt;
            sync_r <= sync_nxt;
            active_r <= active_nxt;
            pattern_r <= pattern_nxt;
            frame_r <= frame_nxt;
            fault_r <= fault_nxt;
            plain_wake_r <= plain_wake_nxt;
            tally_r <= tally_nxt;
            timing_high_r <= timing_high_nxt;
            timing_low_r <= timing_low_nxt;
            mode_prev_r <= mode_prev_nxt;
            ser_r <= ser_nxt;
            sclk_prev_r <= sclk_prev_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_in_r <= shift_in_nxt;
            shift_out_r <= shift_out_nxt;
            sdo_r <= sdo_nxt;
            sdo_oe_n_r <= sdo_oe_n_nxt;
        end
    end

    assign spi_sdo = sdo_r;
    assign spi_sdo_oe_n = sdo_oe_n_r;
    assign system_fault_flag = fault_r;
    assign plain_can_wake_enable = plain_wake_r;
    assign partial_wake_active_flag = active_r;
endmodule : swst_status

/* rtl/swst_pkg.sv */
package swst_pkg;
    // ==========================================
    // Register addresses (7-bit serial address)
    localparam logic [6:0] ADDR_SWITCH_OVERLOAD = 7'h54;
    localparam logic [6:0] ADDR_SWITCH_OPEN_LOAD = 7'h55;
    localparam logic [6:0] ADDR_PARTIAL_WAKE = 7'h70;
    localparam logic [6:0] ADDR_ERROR_TALLY = 7'h71;
    localparam logic [6:0] ADDR_TIMING_HIGH = 7'h72;
    localparam logic [6:0] ADDR_TIMING_LOW = 7'h73;

    // ==========================================
    // Field positions of the partial wake flags register
    localparam int SYNC_BIT = 6;
    localparam int QUIET_BIT = 3;
    localparam int ACTIVE_BIT = 2;
    localparam int PATTERN_BIT = 1;
    localparam int FRAME_BIT = 0;

    // ==========================================
    // Reset values and limits
    localparam logic [7:0] TIMING_HIGH_RESET = 8'hA0;
    localparam logic [3:0] TIMING_LOW_RESET = 4'h0;
    localparam logic [5:0] TALLY_OVERFLOW = 6'h20;
    localparam logic [2:0] MODE_NO_ACTIVATION = 3'h4;
    localparam int MODE_WAKE_BIT = 2;

    // ==========================================
    // Serial frame: 8 command bits then 8 data bits, MSB first
    localparam logic [3:0] CMD_LAST_BIT = 4'h7;
    localparam logic [3:0] FRAME_LAST_BIT = 4'hF;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_CMD = 2'b01,
        SER_DATA = 2'b11
    } swst_ser_e;
endpackage : swst_pkg

/* sim/swst_status_checker.sv */
`timescale 1ns/10ps
module swst_status_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic [2:0] can_mode,
    input wire logic config_valid_bit,
    input wire logic system_fault_flag,
    input wire logic plain_can_wake_enable,
    input wire logic partial_wake_active_flag
);
    // ==========================================
    // Flag relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_active_needs_mode: assert property (partial_wake_active_flag |-> $past(can_mode[2]))
        else $error("active without mode bit 2");
    a_active_needs_valid: assert property ($rose(partial_wake_active_flag) |->
        $past(config_valid_bit) && !$past(system_fault_flag)) else $error("bad activation");
    a_start_on_change: assert property ($rose(partial_wake_active_flag) |->
        $past(can_mode) != 3'h4 && $past(can_mode) != $past(can_mode, 2)) else $error("no change");
    a_fault_needs_mode: assert property ($rose(system_fault_flag) |-> $past(can_mode[2]))
        else $error("fault set with mode bit 2 low");
    a_fault_sticky: assert property ($fell(system_fault_flag) |-> $past(soft_reset))
        else $error("fault cleared without reset");
    a_overflow_actions: assert property ($rose(plain_can_wake_enable) |->
        system_fault_flag && !partial_wake_active_flag) else $error("overflow actions");
    a_soft_clear: assert property ($past(soft_reset) |-> !system_fault_flag &&
        !partial_wake_active_flag && !plain_can_wake_enable) else $error("soft reset");
    a_drop_has_cause: assert property ($fell(partial_wake_active_flag) |->
        system_fault_flag || !$past(can_mode[2]) || $past(soft_reset)) else $error("drop");
endmodule : swst_status_checker

bind swst_status swst_status_checker chk (.clk(clk), .rstn(rstn), .soft_reset(soft_reset),
    .can_mode(can_mode), .config_valid_bit(config_valid_bit),
    .system_fault_flag(system_fault_flag), .plain_can_wake_enable(plain_can_wake_enable),
    .partial_wake_active_flag(partial_wake_active_flag));

/* sim/swst_host.sv */
`timescale 1ns/10ps
module swst_host (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    output logic csn,
    output logic sclk,
    output logic sdi
);
    logic line;
    // Released line shows the inverse, so a stale bit cannot pass
    assign line = sdo_oe_n ? ~sdo : sdo;
    initial begin
        {sclk, sdi} = 2'b00;
        csn = 1'b1;
    end
    // ==========================================
    // One frame, four clk per serial clock phase
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk);
        csn <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            sclk <= 1'b0;
            sdi <= (i < 8) ? cmd[7 - i] : wd[15 - i];
            repeat (4) @(posedge clk);
            if (i > 7) rd = {rd[6:0], line};
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        {sclk, sdi} <= 2'b00;
        repeat (4) @(posedge clk);
        csn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : xfer
endmodule : swst_host

/* sim/test_switch_and_selective_wake_status.sv */
`timescale 1ns/10ps
module test_switch_and_selective_wake_status;
    logic clk, rstn, soft_reset, restart, csn, sclk, sdi, sdo, oe_n;
    logic cfg_ok, cfg_err, fv, fe, sil, wp, wf, rstb, fault, pw, act;
    logic [3:0] ovl, opl;
    logic [2:0] mode;
    logic [11:0] ratio;
    logic [7:0] got;
    int bad_count = 0;
    int n_checks = 0;
    swst_status dut (.clk(clk), .rstn(rstn), .soft_reset(soft_reset), .restart(restart),
        .spi_csn(csn), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe_n(oe_n),
        .switch_overload_evt(ovl), .switch_open_load_evt(opl), .can_mode(mode),
        .config_valid_bit(cfg_ok), .config_error(cfg_err), .frame_valid(fv), .frame_error(fe),
        .bus_silence_exceeded(sil), .wake_pattern_seen(wp), .wake_frame_match(wf),
        .ratio_strobe(rstb), .clocks_per_bit_ratio(ratio), .system_fault_flag(fault),
        .plain_can_wake_enable(pw), .partial_wake_active_flag(act));
    swst_host host (.clk(clk), .sdo(sdo), .sdo_oe_n(oe_n), .csn(csn), .sclk(sclk), .sdi(sdi));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host.xfer({1'b0, a}, 8'h00, got);
        chk($sformatf("reg %h", a), exp, got);
    endtask : rd
    task automatic errs(input int n);
        repeat (n) begin
            fe <= 1'b1;
            wait_n(1);
            fe <= 1'b0;
            wait_n(1);
        end
    endtask : errs
    task automatic give_verdict;
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    initial begin
        wait_n(20000);
        bad_count++;
        give_verdict();
    end
    // ==========================================
    // Sequence
    initial begin
        {rstn, soft_reset, restart, cfg_err, fv, fe, sil, wp, wf, rstb} = '0;
        {ovl, opl, mode, ratio} = '0;
        cfg_ok = 1'b1;
        wait_n(12);
        rstn <= 1'b1;
        rd(7'h54, 8'h00);
        rd(7'h55, 8'h00);
        rd(7'h72, 8'hA0);
        rd(7'h10, 8'h00);
        {ovl, opl} <= 8'hA5;
        wait_n(1);
        {ovl, opl} <= 8'h00;
        rd(7'h54, 8'h0A);
        rd(7'h54, 8'h00);
        host.xfer(8'hD4, 8'hFF, got);
        rd(7'h55, 8'h05);
        ovl <= 4'h1;
        rd(7'h54, 8'h01);
        ovl <= 4'h0;
        rd(7'h54, 8'h01);
        {rstb, ratio} <= 13'h1ABC;
        mode <= 3'h4;
        wait_n(3);
        rstb <= 1'b0;
        chk("active", 8'h00, {7'h00, act});
        rd(7'h73, 8'hC0);
        mode <= 3'h5;
        sil <= 1'b1;
        rd(7'h70, 8'h0C);
        sil <= 1'b0;
        {fv, wp, wf, ovl} <= 7'h73;
        wait_n(1);
        {fv, wp, wf, ovl} <= 7'h00;
        restart <= 1'b1;
        wait_n(1);
        restart <= 1'b0;
        rd(7'h70, 8'h47);
        rd(7'h54, 8'h03);
        rd(7'h72, 8'hAB);
        errs(3);
        rd(7'h71, 8'h03);
        fv <= 1'b1;
        wait_n(1);
        fv <= 1'b0;
        rd(7'h71, 8'h02);
        errs(29);
        rd(7'h71, 8'h1F);
        errs(1);
        chk("fault wake active", 8'h06, {5'h00, fault, pw, act});
        rd(7'h71, 8'h20);
        mode <= 3'h0;
        soft_reset <= 1'b1;
        wait_n(1);
        soft_reset <= 1'b0;
        rd(7'h71, 8'h00);
        rd(7'h70, 8'h00);
        rd(7'h72, 8'hA0);
        cfg_err <= 1'b1;
        wait_n(1);
        cfg_err <= 1'b0;
        wait_n(2);
        chk("fault wake active", 8'h00, {5'h00, fault, pw, act});
        cfg_ok <= 1'b0;
        mode <= 3'h5;
        wait_n(3);
        chk("active", 8'h00, {7'h00, act});
        cfg_ok <= 1'b1;
        mode <= 3'h6;
        wait_n(3);
        chk("active", 8'h01, {7'h00, act});
        cfg_err <= 1'b1;
        wait_n(1);
        cfg_err <= 1'b0;
        wait_n(2);
        chk("fault", 8'h01, {7'h00, fault});
        give_verdict();
    end
endmodule : test_switch_and_selective_wake_status
